// ### tb/motor_thermal_tb.sv
`timescale 1ns/1ps
module motor_thermal_tb;
  localparam int TK = 4;
  localparam int LIM = 25600;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, low_speed;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] output_current;
  logic second_set_select, external_thermal_in, reset_signal_in;
  logic thermal_prealarm_out, prealarm_indication, motor_overload_fault;
  logic external_thermal_fault, trip_out, irq, term_n;
  int fail_count, n_checks, seed, n, cur, f, s, m, e1, e2, xr, rs, ex;
  int rv[9] = '{32'h3E8, 32'h10000, 0, 32'h270F, 32'h10, 0, 0, 0, 0};
  int sm[5] = '{0, 2, 1, 9999, 5000};
  motor_thermal #(.TICK_CYCLES(TK)) u_dut
  (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .output_current(output_current),
    .low_speed(low_speed), .second_set_select(second_set_select),
    .external_thermal_in(external_thermal_in),
    .reset_signal_in(reset_signal_in),
    .thermal_prealarm_out(thermal_prealarm_out),
    .prealarm_indication(prealarm_indication),
    .motor_overload_fault(motor_overload_fault),
    .external_thermal_fault(external_thermal_fault),
    .trip_out(trip_out), .irq(irq)
  );
  thermal_field u_field
  (
    .hclk(hclk), .thermal_prealarm_out(thermal_prealarm_out),
    .output_current(output_current), .low_speed(low_speed),
    .second_set_select(second_set_select),
    .external_thermal_in(external_thermal_in),
    .reset_signal_in(reset_signal_in), .prealarm_terminal_n(term_n)
  );
  initial
  begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic results;
    $display("checks=%0d errors=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results
  task automatic wait_rdy;
    int k;
    k = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
    begin
      if (++k > 50)
      begin
        fail_count++;
        results();
      end
      @(posedge hclk);
    end
  endtask : wait_rdy
  task automatic xfer(input logic w, input int a, input int wd,
                      output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= a;
    wait_rdy();
    // Select may stay up across an idle slot
    hsel <= 1'($urandom);
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask : xfer
  task automatic wr(input int a, input int wd);
    logic [31:0] x;
    xfer(1'b1, a, wd, x);
  endtask : wr
  task automatic rdchk(input int a, input logic [31:0] exp);
    logic [31:0] x;
    xfer(1'b0, a, 0, x);
    chk(x, exp);
  endtask : rdchk
  // Waits up to lim cycles for sig to reach v
  task automatic wait_for(ref logic sig, input logic v, input int lim);
    int k;
    k = 0;
    while (sig !== v)
    begin
      if (++k > lim)
      begin
        fail_count++;
        results();
      end
      @(posedge hclk);
    end
  endtask : wait_for
  function automatic bit legal(int c);
    return c inside {0, 1, [3:6], [13:16], 23, 24, 40, 43, 44, 50, 53, 54};
  endfunction : legal
  // Channel modes: 0 off, 1 integrate, 2 cool; s < 0 means none
  function automatic int mode1(int f, int s, int m, int sel);
    if (f == 0)
      return 0;
    if (sel == 0 || (s < 0 && m == 9999))
      return 1;
    return 2;
  endfunction : mode1
  function automatic int mode2(int f, int s, int m, int sel);
    if (!(s > 0 || (s < 0 && f != 0 && m != 9999)))
      return 0;
    return sel ? 1 : 2;
  endfunction : mode2
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    fail_count = 0;
    n_checks = 0;
    seed = $urandom(41478);
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (rv[i]) rdchk(i * 4, rv[i]);
    rdchk(32'h40, 0);
    chk({hreadyout, hresp}, 2'b10);
    cur = 0;
    for (int c = 0; c < 60; c++)
    begin
      wr(8, c);
      cur = legal(c) ? c : cur;
      rdchk(8, cur);
    end
    cur = 9999;
    foreach (sm[i])
    begin
      wr(12, sm[i]);
      cur = (sm[i] inside {0, 1, 9999}) ? sm[i] : cur;
      rdchk(12, cur);
    end
    for (int i = 0; i < 24; i++)
    begin
      f = i[0] ? 1 + $urandom % 50000 : 0;
      s = (i[2:1] == 0) ? -1 : (i[2:1] == 1) ? 0 : 1 + $urandom % 50000;
      m = i[3] ? 0 : 9999;
      u_field.load($urandom % 4000, i[1]);
      wr(0, f);
      wr(4, s < 0 ? 32'h10000 : s);
      wr(12, m);
      u_field.set_sel(i[4]);
      repeat (3 * TK) @(posedge hclk);
      e1 = mode1(f, s, m, i[4]);
      e2 = mode2(f, s, m, i[4]);
      xfer(1'b0, 16, 0, d);
      chk(d[7:4], {e2[1:0], e1[1:0]});
      // Motor type left at a constant-torque code
      chk(d[8], (i[4] && m == 0) ? 0 : 1);
      if (e1 == 0) rdchk(20, 0);
      if (e2 == 0) rdchk(24, 0);
    end
    hresetn <= 1'b0;
    u_field.set_sel(1'b0);
    u_field.load(16'd300, 1'b0);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk(motor_overload_fault, 0);
    rdchk(0, 32'h3E8);
    wr(0, 100);
    wr(32, 7);
    wait_for(thermal_prealarm_out, 1'b1, 3000);
    // Sticky status lands one edge after the prealarm
    @(posedge hclk);
    chk(prealarm_indication, 1);
    chk(term_n, 0);
    chk(trip_out, 0);
    chk(irq, 1);
    xfer(1'b0, 20, 0, d);
    chk(d * 20 >= LIM * 17, 1);
    wait_for(motor_overload_fault, 1'b1, 3000);
    chk(trip_out, 1);
    xfer(1'b0, 20, 0, d);
    chk(d >= LIM, 1);
    u_field.load(16'd0, 1'b0);
    wait_for(thermal_prealarm_out, 1'b0, 3000);
    xfer(1'b0, 20, 0, d);
    chk(d * 20 < LIM * 17, 1);
    chk(motor_overload_fault, 1);
    u_field.fault_reset(1'b1);
    u_field.fault_reset(1'b0);
    @(posedge hclk);
    chk(motor_overload_fault, 0);
    chk(trip_out, 0);
    rdchk(28, 3);
    wr(32, 0);
    @(posedge hclk);
    chk(irq, 0);
    wr(28, 3);
    rdchk(28, 0);
    wr(32, 7);
    u_field.relay(1'b1);
    repeat (2) @(posedge hclk);
    chk(external_thermal_fault, 1);
    chk(trip_out, 1);
    chk(irq, 1);
    u_field.relay(1'b0);
    rdchk(28, 4);
    chk(external_thermal_fault, 1);
    u_field.fault_reset(1'b1);
    u_field.fault_reset(1'b0);
    @(posedge hclk);
    chk(external_thermal_fault, 0);
    wr(28, 4);
    @(posedge hclk);
    chk(irq, 0);
    // Random relay and reset contacts, set wins over clear
    ex = 0;
    for (int j = 0; j < 40; j++)
    begin
      xr = $urandom % 2;
      rs = $urandom % 2;
      u_field.contacts(xr[0], rs[0]);
      repeat (2) @(posedge hclk);
      ex = xr | (ex & (1 - rs));
      chk(external_thermal_fault, ex);
    end
    results();
  end
endmodule : motor_thermal_tb

// ### tb/thermal_field.sv
`timescale 1ns/1ps
module thermal_field
(
  input wire logic hclk, // Clock
  input wire logic thermal_prealarm_out, // Prealarm from the drive
  output logic [15:0] output_current, // Sensed motor current
  output logic low_speed, // Motor below rated speed
  output logic second_set_select, // Select terminal
  output logic external_thermal_in, // External relay contact
  output logic reset_signal_in, // Fault reset terminal
  output logic prealarm_terminal_n // Prealarm terminal, low-true
);
  initial
  begin
    output_current = 16'h0000;
    low_speed = 1'b0;
    second_set_select = 1'b0;
    external_thermal_in = 1'b0;
    reset_signal_in = 1'b0;
  end
  // Output terminal programmed for low-true prealarm
  assign prealarm_terminal_n = ~thermal_prealarm_out;
  ////////////////////////////////////////////////////////////////////////////
  task automatic load(input logic [15:0] cur, input logic slow);
    @(posedge hclk);
    output_current <= cur;
    low_speed <= slow;
  endtask : load
  // Input terminal programmed as set select
  task automatic set_sel(input logic v);
    @(posedge hclk);
    second_set_select <= v;
  endtask : set_sel
  // Input terminal programmed as external relay
  task automatic relay(input logic v);
    @(posedge hclk);
    external_thermal_in <= v;
  endtask : relay
  task automatic fault_reset(input logic v);
    @(posedge hclk);
    reset_signal_in <= v;
  endtask : fault_reset
  // Relay contact and reset terminal moved at one edge
  task automatic contacts(input logic x, input logic r);
    @(posedge hclk);
    external_thermal_in <= x;
    reset_signal_in <= r;
  endtask : contacts
endmodule : thermal_field

// ### verilog/motor_thermal.sv
`timescale 1ns/1ps
module motor_thermal
#(
  parameter int TICK_CYCLES = thermal_pkg::SAMPLE_CYCLES
)
(
  input wire logic hclk, // Clock, 40 MHz
  input wire logic hresetn, // Async reset, active low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write
  input wire logic [2:0] hsize, // Size
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  output logic hreadyout, // Slave ready
  output logic hresp, // Response
  output logic [31:0] hrdata, // Read data
  input wire logic [15:0] output_current, // Measured current, 0.01 A
  input wire logic low_speed, // Motor below rated speed
  input wire logic second_set_select, // Second set select
  input wire logic external_thermal_in, // External relay operated
  input wire logic reset_signal_in, // Fault reset input
  output logic thermal_prealarm_out, // Prealarm
  output logic prealarm_indication, // Prealarm display
  output logic motor_overload_fault, // Motor overload trip
  output logic external_thermal_fault, // External thermal trip
  output logic trip_out, // Drive output stop
  output logic irq // Interrupt, active high
);
  typedef struct packed
  {
    logic [15:0] first_cur;
    logic [15:0] second_cur;
    logic second_none;
    logic [7:0] motor_type;
    logic [13:0] second_motor;
    logic [2:0] irq_mask;
    logic [2:0] irq_stat;
    logic mflt;
    logic xflt;
    logic pre;
    logic pre_d;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
    logic [31:0] tick_cnt;
    logic tick;
  } top_s;
  top_s st_r;
  top_s st_nxt;

  thermal_pkg::ch_mode_e mode1;
  thermal_pkg::ch_mode_e mode2;
  logic [31:0] acc1;
  logic [31:0] acc2;
  logic pre1;
  logic pre2;
  logic over1;
  logic over2;
  logic c1_zero;
  logic m2_none;
  logic s2_valid;
  logic ch2_ok;
  logic const_torque;
  logic slow_cool;
  logic pre_now;
  logic over_now;
  logic addr_ok;
  logic [31:0] status;

  function automatic logic motor_code_ok(input logic [7:0] c);
    case (c)
      8'd0, 8'd1, 8'd3, 8'd4, 8'd5, 8'd6, 8'd13, 8'd14, 8'd15, 8'd16,
      8'd23, 8'd24, 8'd40, 8'd43, 8'd44, 8'd50, 8'd53, 8'd54:
        motor_code_ok = 1'b1;
      default:
        motor_code_ok = 1'b0;
    endcase
  endfunction : motor_code_ok

  function automatic logic motor_code_ct(input logic [7:0] c);
    case (c)
      8'd1, 8'd13, 8'd14, 8'd15, 8'd16, 8'd50, 8'd53, 8'd54:
        motor_code_ct = 1'b1;
      default:
        motor_code_ct = 1'b0;
    endcase
  endfunction : motor_code_ct

  ////////////////////////////////////////////////////////////////////////
  // Channel mode decode

  assign c1_zero = (st_r.first_cur == 16'h0000);
  assign m2_none = (st_r.second_motor == thermal_pkg::MOTOR_NONE);
  assign s2_valid = !st_r.second_none && (st_r.second_cur != 16'h0000);
  assign ch2_ok = s2_valid || (st_r.second_none && !c1_zero
    && !m2_none);

  always_comb
  begin
    if (c1_zero)
      mode1 = thermal_pkg::CH_OFF;
    else if (!second_set_select)
      mode1 = thermal_pkg::CH_INTEG;
    else if (st_r.second_none && m2_none)
      mode1 = thermal_pkg::CH_INTEG;
    else
      mode1 = thermal_pkg::CH_COOL;
    if (!ch2_ok)
      mode2 = thermal_pkg::CH_OFF;
    else if (second_set_select)
      mode2 = thermal_pkg::CH_INTEG;
    else
      mode2 = thermal_pkg::CH_COOL;
  end

  // Second motor characteristic applies under select whenever a second motor is set
  assign const_torque = (second_set_select && !m2_none)
    ? st_r.second_motor[0] : motor_code_ct(st_r.motor_type);
  assign slow_cool = low_speed && !const_torque;

  thermal_channel u_ch1
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(st_r.tick),
    .mode(mode1),
    .slow_cool(slow_cool),
    .current(output_current),
    .setting(st_r.first_cur),
    .acc(acc1),
    .prealarm(pre1),
    .over(over1)
  );

  thermal_channel u_ch2
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(st_r.tick),
    .mode(mode2),
    .slow_cool(slow_cool),
    .current(output_current),
    .setting(st_r.second_cur),
    .acc(acc2),
    .prealarm(pre2),
    .over(over2)
  );

  assign pre_now = (mode1 == thermal_pkg::CH_INTEG && pre1)
    || (mode2 == thermal_pkg::CH_INTEG && pre2);
  assign over_now = (mode1 == thermal_pkg::CH_INTEG && over1)
    || (mode2 == thermal_pkg::CH_INTEG && over2);

  ////////////////////////////////////////////////////////////////////////
  // Bus decode and read mux

  assign addr_ok = hsel && hready && htrans[1];
  always_comb
  begin
    status = 32'h0000_0000;
    status[thermal_pkg::ST_PRE_BIT] = st_r.pre;
    status[thermal_pkg::ST_MFLT_BIT] = st_r.mflt;
    status[thermal_pkg::ST_XFLT_BIT] = st_r.xflt;
    status[thermal_pkg::ST_CH1_LSB +: 2] = mode1;
    status[thermal_pkg::ST_CH2_LSB +: 2] = mode2;
    status[thermal_pkg::ST_CT_BIT] = const_torque;
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    st_nxt = st_r;
    // Sample tick
    st_nxt.tick = 1'b0;
    if (st_r.tick_cnt >= 32'(TICK_CYCLES - 1))
    begin
      st_nxt.tick_cnt = 32'h0000_0000;
      st_nxt.tick = 1'b1;
    end
    else
      st_nxt.tick_cnt = st_r.tick_cnt + 32'h0000_0001;
    // Address phase
    st_nxt.wr_pend = 1'b0;
    if (addr_ok)
    begin
      st_nxt.wr_pend = hwrite;
      st_nxt.wr_addr = haddr[7:0];
      st_nxt.rdata = 32'h0000_0000;
      if (!hwrite)
      begin
        unique case (haddr[7:0])
          thermal_pkg::OFS_FIRST_CUR:
            st_nxt.rdata = {16'h0000, st_r.first_cur};
          thermal_pkg::OFS_SECOND_CUR:
            st_nxt.rdata = {15'h0000, st_r.second_none, st_r.second_cur};
          thermal_pkg::OFS_MOTOR_TYPE:
            st_nxt.rdata = {24'h000000, st_r.motor_type};
          thermal_pkg::OFS_SECOND_MOTOR:
            st_nxt.rdata = {18'h00000, st_r.second_motor};
          thermal_pkg::OFS_STATUS:
            st_nxt.rdata = status;
          thermal_pkg::OFS_ACC1:
            st_nxt.rdata = acc1;
          thermal_pkg::OFS_ACC2:
            st_nxt.rdata = acc2;
          thermal_pkg::OFS_IRQ_STAT:
            st_nxt.rdata = {29'h0000_0000, st_r.irq_stat};
          thermal_pkg::OFS_IRQ_MASK:
            st_nxt.rdata = {29'h0000_0000, st_r.irq_mask};
          default:
            st_nxt.rdata = 32'h0000_0000;
        endcase
      end
    end
    // Data phase write
    if (st_r.wr_pend)
    begin
      unique case (st_r.wr_addr)
        thermal_pkg::OFS_FIRST_CUR:
          if (hwdata[15:0] <= thermal_pkg::CUR_MAX)
            st_nxt.first_cur = hwdata[15:0];
        thermal_pkg::OFS_SECOND_CUR:
          if (hwdata[thermal_pkg::SECOND_NONE_BIT]
              || hwdata[15:0] <= thermal_pkg::CUR_MAX)
          begin
            st_nxt.second_cur = hwdata[15:0];
            st_nxt.second_none = hwdata[thermal_pkg::SECOND_NONE_BIT];
          end
        thermal_pkg::OFS_MOTOR_TYPE:
          if (hwdata[31:8] == 24'h000000 && motor_code_ok(hwdata[7:0]))
            st_nxt.motor_type = hwdata[7:0];
        thermal_pkg::OFS_SECOND_MOTOR:
          if (hwdata[31:14] == 18'h00000 && (hwdata[13:1] == 13'h0000
              || hwdata[13:0] == thermal_pkg::MOTOR_NONE))
            st_nxt.second_motor = hwdata[13:0];
        thermal_pkg::OFS_IRQ_STAT:
          st_nxt.irq_stat = st_r.irq_stat & ~hwdata[2:0];
        thermal_pkg::OFS_IRQ_MASK:
          st_nxt.irq_mask = hwdata[2:0];
        default:
          st_nxt.irq_mask = st_r.irq_mask;
      endcase
    end
    // Prealarm follows the active channel, never trips
    st_nxt.pre = pre_now;
    st_nxt.pre_d = st_r.pre;
    // Fault latches; reset input clears, a new event wins
    if (reset_signal_in)
    begin
      st_nxt.mflt = 1'b0;
      st_nxt.xflt = 1'b0;
    end
    if (over_now)
      st_nxt.mflt = 1'b1;
    if (external_thermal_in)
      st_nxt.xflt = 1'b1;
    // Sticky events, set wins over clear
    if (st_r.pre && !st_r.pre_d)
      st_nxt.irq_stat[thermal_pkg::IRQ_PRE] = 1'b1;
    if (over_now && !st_r.mflt)
      st_nxt.irq_stat[thermal_pkg::IRQ_MFLT] = 1'b1;
    if (external_thermal_in && !st_r.xflt)
      st_nxt.irq_stat[thermal_pkg::IRQ_XFLT] = 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_r <= '0;
      st_r.first_cur <= thermal_pkg::FIRST_CUR_RST;
      st_r.second_cur <= thermal_pkg::SECOND_CUR_RST;
      st_r.second_none <= thermal_pkg::SECOND_NONE_RST;
      st_r.motor_type <= thermal_pkg::MOTOR_TYPE_RST;
      st_r.second_motor <= thermal_pkg::MOTOR_NONE;
    end
    else
      st_r <= st_nxt;
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st_r.rdata;
  assign thermal_prealarm_out = st_r.pre;
  assign prealarm_indication = st_r.pre;
  assign motor_overload_fault = st_r.mflt;
  assign external_thermal_fault = st_r.xflt;
  assign trip_out = st_r.mflt || st_r.xflt;
  assign irq = |(st_r.irq_stat & st_r.irq_mask);

  ////////////////////////////////////////////////////////////////////////
  // Checks

  property p_pre_follow;
    @(posedge hclk) disable iff (!hresetn)
    pre_now |=> thermal_prealarm_out;
  endproperty
  a_pre_follow: assert property (p_pre_follow)
    else $error("prealarm not raised at 85 percent");

  property p_pre_drop;
    @(posedge hclk) disable iff (!hresetn)
    !pre_now |=> !thermal_prealarm_out;
  endproperty
  a_pre_drop: assert property (p_pre_drop)
    else $error("prealarm held below threshold");

  property p_no_pre_trip;
    @(posedge hclk) disable iff (!hresetn)
    (!trip_out && !over_now && !external_thermal_in) |=> !trip_out;
  endproperty
  a_no_pre_trip: assert property (p_no_pre_trip)
    else $error("trip without a trip cause");

  property p_over_trip;
    @(posedge hclk) disable iff (!hresetn)
    over_now |=> motor_overload_fault && trip_out;
  endproperty
  a_over_trip: assert property (p_over_trip)
    else $error("overload did not trip");

  property p_ext_trip;
    @(posedge hclk) disable iff (!hresetn)
    external_thermal_in |=> external_thermal_fault && trip_out;
  endproperty
  a_ext_trip: assert property (p_ext_trip)
    else $error("external relay did not trip");

  property p_fault_hold;
    @(posedge hclk) disable iff (!hresetn)
    (motor_overload_fault && !reset_signal_in) |=> motor_overload_fault;
  endproperty
  a_fault_hold: assert property (p_fault_hold)
    else $error("fault cleared without reset");

  property p_ch2_select;
    @(posedge hclk) disable iff (!hresetn)
    (second_set_select && s2_valid) |-> mode2 == thermal_pkg::CH_INTEG;
  endproperty
  a_ch2_select: assert property (p_ch2_select)
    else $error("second channel not live under select");

  property p_ch1_zero;
    @(posedge hclk) disable iff (!hresetn)
    c1_zero |-> mode1 == thermal_pkg::CH_OFF;
  endproperty
  a_ch1_zero: assert property (p_ch1_zero)
    else $error("first channel live with zero setting");

  property p_motor_legal;
    @(posedge hclk) disable iff (!hresetn)
    1'b1 |-> motor_code_ok(st_r.motor_type);
  endproperty
  a_motor_legal: assert property (p_motor_legal)
    else $error("illegal motor type stored");
endmodule : motor_thermal

// ### verilog/thermal_channel.sv
`timescale 1ns/1ps
module thermal_channel
(
  input wire logic hclk, // Clock
  input wire logic hresetn, // Async reset, active low
  input wire logic tick, // Sample strobe
  input wire thermal_pkg::ch_mode_e mode, // Off, integrate or cool
  input wire logic slow_cool, // Reduced cooling
  input wire logic [15:0] current, // Output current
  input wire logic [15:0] setting, // Thermal current setting
  output logic [31:0] acc, // Cumulative value
  output logic prealarm, // At or above 85 %
  output logic over // At or above 100 %
);
  typedef struct packed
  {
    logic [31:0] acc;
  } ch_s;
  ch_s st_r;
  ch_s st_nxt;
  logic [31:0] limit;
  logic [15:0] eff_cur;
  logic [15:0] cool;
  logic [31:0] sum;

  assign limit = {8'h00, setting, 8'h00};
  assign acc = st_r.acc;
  assign prealarm = ({8'h00, st_r.acc} * thermal_pkg::PRE_DEN)
    >= ({8'h00, limit} * thermal_pkg::PRE_NUM);
  assign over = (st_r.acc >= limit) && (setting != 16'h0000);

  always_comb
  begin
    st_nxt = st_r;
    eff_cur = (mode == thermal_pkg::CH_COOL) ? 16'h0000 : current;
    cool = 16'h0000;
    sum = st_r.acc;
    if (eff_cur >= setting)
      sum = st_r.acc + {16'h0000, eff_cur - setting};
    else
    begin
      cool = slow_cool ? ((setting - eff_cur) >> 1) : (setting - eff_cur);
      sum = (st_r.acc > {16'h0000, cool}) ? st_r.acc - {16'h0000, cool}
        : 32'h0000_0000;
    end
    if (sum > limit)
      sum = limit;
    if (mode == thermal_pkg::CH_OFF)
      st_nxt.acc = 32'h0000_0000;
    else if (tick)
      st_nxt.acc = sum;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  property p_off_clear;
    @(posedge hclk) disable iff (!hresetn)
    (mode == thermal_pkg::CH_OFF) |=> (acc == 32'h0000_0000);
  endproperty
  a_off_clear: assert property (p_off_clear)
    else $error("inactive channel accumulated");

  property p_hold;
    @(posedge hclk) disable iff (!hresetn)
    (!tick && mode != thermal_pkg::CH_OFF) |=> $stable(acc);
  endproperty
  a_hold: assert property (p_hold)
    else $error("accumulator moved without tick");

  property p_cool_down;
    @(posedge hclk) disable iff (!hresetn)
    (tick && mode == thermal_pkg::CH_COOL && acc != 32'h0000_0000
      && setting != 16'h0000) |=> (acc < $past(acc));
  endproperty
  a_cool_down: assert property (p_cool_down)
    else $error("cooling did not lower the value");
endmodule : thermal_channel

// ### verilog/thermal_pkg.sv
package thermal_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_FIRST_CUR = 8'h00;
  localparam logic [7:0] OFS_SECOND_CUR = 8'h04;
  localparam logic [7:0] OFS_MOTOR_TYPE = 8'h08;
  localparam logic [7:0] OFS_SECOND_MOTOR = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_ACC1 = 8'h14;
  localparam logic [7:0] OFS_ACC2 = 8'h18;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h1C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h20;
  // Field positions
  localparam int SECOND_NONE_BIT = 16;
  localparam int ST_PRE_BIT = 0;
  localparam int ST_MFLT_BIT = 1;
  localparam int ST_XFLT_BIT = 2;
  localparam int ST_CH1_LSB = 4;
  localparam int ST_CH2_LSB = 6;
  localparam int ST_CT_BIT = 8;
  localparam int IRQ_PRE = 0;
  localparam int IRQ_MFLT = 1;
  localparam int IRQ_XFLT = 2;
  // Reset values; currents in 0.01 A
  localparam logic [15:0] FIRST_CUR_RST = 16'h03E8;
  localparam logic [15:0] SECOND_CUR_RST = 16'h0000;
  localparam logic SECOND_NONE_RST = 1'b1;
  localparam logic [7:0] MOTOR_TYPE_RST = 8'h00;
  localparam logic [13:0] MOTOR_NONE = 14'd9999;
  localparam logic [15:0] CUR_MAX = 16'd50000;
  // Trip level is setting shifted up; prealarm at 17/20 = 85 %
  localparam int TRIP_SHIFT = 8;
  localparam logic [39:0] PRE_NUM = 40'd17;
  localparam logic [39:0] PRE_DEN = 40'd20;
  // Integration sample period
  localparam int SAMPLE_NS = 1000000;
  localparam int CLK_NS = 25;
  localparam int SAMPLE_CYCLES = SAMPLE_NS / CLK_NS;
  typedef enum logic [1:0]
  {
    CH_OFF = 2'b00,
    CH_INTEG = 2'b01,
    CH_COOL = 2'b10
  } ch_mode_e;
endpackage : thermal_pkg
